// *** logic/cache_memory_port_arbiter.sv ***
/*
  Memory port arbiter of the cache: peripheral-bus map, four storage bus
  controllers and the CPU share one main-memory bus.
  Assumes requesters hold request and fields stable until their done pulse.
*/
// Notes on behaviour
// - Controller port: 22 address, 36 data bits, three type signals, shared bus.
// - Direction high means write; double-word high means two words.
// - Controller transfers bypass cache; controller writes invalidate hit entries.
// - Requests are arbitrated; only the highest priority one is acknowledged.
// - Granted controller gets address gate with data drive on writes, then latch select on reads.
// - Priority order: map, controllers A to D, then CPU.
// - CPU or map write hit updates cache and memory; misses do not allocate.
// - CPU or map read hit returns cached word without a memory cycle.
// - CPU or map read miss fills both block words, then returns word.
// - The data store holds 1024 words.
// - Memory bus: 22 address, address parity, 36 data, four byte masks.
// - Peripheral port maps 18-bit to 22-bit addresses, 16-bit data path.
// - Map holds 31 read/write 22-bit relocation registers, two halves each.
// - Peripheral address bits 13 to 17 select the relocation register.
// - All-ones selector means I/O space and is never mapped to memory.
// - After initialize the map is identity until relocation is enabled.
// - Relocated address is register bits 1 to 21 plus the offset.
// - CPU port: 22-bit address, 16-bit data, parity abort, two controls.
`timescale 1ns/1ps
`default_nettype none
module cache_memory_port_arbiter (
  input wire logic clk,
  input wire logic nrst,
  input wire logic init,
  input wire logic relocation_enable,
  input wire cache_pkg::word_req_s periph_in,
  output logic periph_ack,
  output logic periph_done,
  output logic periph_parity_err,
  output logic periph_io_space,
  output logic [cache_pkg::WORD_W-1:0] periph_rdata,
  input wire logic map_reg_we,
  input wire logic [cache_pkg::MAP_SEL_W-1:0] map_reg_sel,
  input wire logic map_reg_hi,
  input wire logic [cache_pkg::WORD_W-1:0] map_reg_wdata,
  output logic [cache_pkg::WORD_W-1:0] map_reg_rdata,
  input wire cache_pkg::word_req_s cpu_in,
  output logic cpu_ack,
  output logic cpu_done,
  output logic cpu_parity_abort,
  output logic [cache_pkg::WORD_W-1:0] cpu_rdata,
  input wire logic [cache_pkg::NUM_CTL-1:0] ctl_req,
  output logic [cache_pkg::NUM_CTL-1:0] ctl_ack,
  output logic [cache_pkg::NUM_CTL-1:0] ctl_gate_addr,
  output logic [cache_pkg::NUM_CTL-1:0] ctl_drive_data,
  output logic [cache_pkg::NUM_CTL-1:0] ctl_take_data,
  input wire cache_pkg::ctl_bus_s ctl_bus_in,
  output logic [cache_pkg::MEM_DATA_W-1:0] ctl_data_out,
  output logic ctl_data_oe,
  output cache_pkg::mem_cmd_s mem_cmd,
  input wire logic mem_ack,
  input wire logic [cache_pkg::MEM_DATA_W-1:0] mem_rdata
);
  import cache_pkg::*;

  state_s s;
  state_s next_s;
  logic [NUM_REQ-1:0] reqv;
  logic [MAP_SEL_W-1:0] psel;
  logic [ADDR_W-1:0] phys;
  logic cur_hit;
  logic bus_hit;
  who_e win;

  function automatic who_e pick(input logic [NUM_REQ-1:0] r);
    pick = WHO_CPU;
    for (int i = NUM_REQ - 1; i >= 0; i--) begin
      if (r[i]) begin
        pick = who_e'(i[2:0]);
      end
    end
  endfunction

  function automatic logic is_hit(input logic [ADDR_W-1:0] a);
    is_hit = s.valid[a[TAG_LO-1:IDX_LO]] && s.tag[a[TAG_LO-1:IDX_LO]] == a[ADDR_W-1:TAG_LO];
  endfunction

  // Odd parity, one bit per byte lane.
  function automatic logic [3:0] par4(input logic [31:0] d);
    par4 = {~^d[31:24], ~^d[23:16], ~^d[15:8], ~^d[7:0]};
  endfunction

  function automatic mem_cmd_s mem_start(input logic [ADDR_W-1:0] a, input logic wr,
                                         input logic [3:0] m, input logic [MEM_DATA_W-1:0] d);
    mem_start.req = 1'b1;
    mem_start.addr = a;
    mem_start.addr_parity = ~^{a, wr, m};
    mem_start.write = wr;
    mem_start.byte_mask = m;
    mem_start.wdata = d;
  endfunction

  function automatic logic [3:0] word_mask(input cur_s c);
    if (c.dword) begin
      word_mask = MASK_ALL;
    end else if (c.bytew) begin
      word_mask = 4'h1 << {c.addr[1], c.addr[0]};
    end else begin
      word_mask = c.addr[1] ? MASK_HI : MASK_LO;
    end
  endfunction

  // I/O space is kept out of arbitration so it can never reach memory.
  assign psel = periph_in.addr[PADDR_W-1:MAP_SEL_LO];
  assign periph_io_space = psel == MAP_IO_SEL;
  assign reqv = {cpu_in.req, ctl_req, periph_in.req & ~periph_io_space};
  assign win = pick(reqv);
  assign cur_hit = is_hit(s.cur.addr);
  assign bus_hit = is_hit(ctl_bus_in.addr);

  always_comb begin
    phys = {{(ADDR_W - PADDR_W){1'b0}}, periph_in.addr[PADDR_W-1:0]};
    if (s.reloc && psel != MAP_IO_SEL) begin
      phys = {s.map[psel][MAP_REG_W-1:1], 1'b0}
           + {{(ADDR_W - MAP_OFS_W){1'b0}}, periph_in.addr[MAP_OFS_W-1:0]};
    end
  end

  always_comb begin
    logic [WORD_W-1:0] w;
    logic [IDX_W-1:0] idx;
    w = '0;
    idx = s.cur.addr[TAG_LO-1:IDX_LO];
    next_s = s;
    next_s.ack = '0;
    next_s.perr = 1'b0;
    next_s.reloc = relocation_enable & ~init;
    if (map_reg_we && map_reg_sel != MAP_IO_SEL) begin
      if (map_reg_hi) begin
        next_s.map[map_reg_sel][MAP_REG_W-1:WORD_W] = map_reg_wdata[MAP_REG_W-WORD_W-1:0];
      end else begin
        next_s.map[map_reg_sel][WORD_W-1:0] = map_reg_wdata;
      end
    end
    next_s.map_rdata = '0;
    if (map_reg_sel != MAP_IO_SEL) begin
      next_s.map_rdata = map_reg_hi
        ? {{(2 * WORD_W - MAP_REG_W){1'b0}}, s.map[map_reg_sel][MAP_REG_W-1:WORD_W]}
        : s.map[map_reg_sel][WORD_W-1:0];
    end
    case (s.state)
      ST_IDLE: begin
        if (|reqv) begin
          next_s.who = win;
          next_s.ack[win] = 1'b1;
          next_s.state = ST_LOOK;
          if (win == WHO_MAP) begin
            next_s.cur = {phys, periph_in.transfer_direction, 1'b0,
                          periph_in.cycle_modifier & periph_in.transfer_direction,
                          par4({2{periph_in.wdata}}), {2{periph_in.wdata}}};
          end else if (win == WHO_CPU) begin
            next_s.cur = {cpu_in.addr, cpu_in.transfer_direction, 1'b0,
                          cpu_in.cycle_modifier & cpu_in.transfer_direction,
                          par4({2{cpu_in.wdata}}), {2{cpu_in.wdata}}};
          end else begin
            next_s.state = ST_GATE;
          end
        end
      end
      ST_GATE: begin
        // Cycle modifier is ignored: controllers only do plain reads and writes.
        next_s.cur = {ctl_bus_in.addr, ctl_bus_in.transfer_direction,
                      ctl_bus_in.double_word_select | ~ctl_bus_in.transfer_direction,
                      1'b0, ctl_bus_in.data};
        if (ctl_bus_in.transfer_direction && bus_hit) begin
          next_s.valid[ctl_bus_in.addr[TAG_LO-1:IDX_LO]] = 1'b0;
        end
        next_s.mem = mem_start(ctl_bus_in.addr, ctl_bus_in.transfer_direction,
                               word_mask(next_s.cur), ctl_bus_in.data);
        next_s.state = ST_MEM;
      end
      ST_LOOK: begin
        if (!s.cur.write && cur_hit) begin
          next_s.rdata = s.data[s.cur.addr[TAG_LO-1:1]];
          next_s.state = ST_DONE;
        end else begin
          if (s.cur.write && cur_hit) begin
            w = s.data[s.cur.addr[TAG_LO-1:1]];
            if (!s.cur.bytew) begin
              w = s.cur.wdata[WORD_W-1:0];
            end else if (s.cur.addr[0]) begin
              w[15:8] = s.cur.wdata[15:8];
            end else begin
              w[7:0] = s.cur.wdata[7:0];
            end
            next_s.data[s.cur.addr[TAG_LO-1:1]] = w;
          end
          next_s.mem = mem_start(s.cur.addr, s.cur.write,
                                 s.cur.write ? word_mask(s.cur) : MASK_ALL,
                                 s.cur.wdata);
          next_s.state = ST_MEM;
        end
      end
      ST_MEM: begin
        if (mem_ack) begin
          next_s.mem.req = 1'b0;
          next_s.state = ST_DONE;
          if (!s.cur.write) begin
            next_s.ctl_data = mem_rdata;
            if (s.who == WHO_MAP || s.who == WHO_CPU) begin
              next_s.data[{idx, 1'b0}] = mem_rdata[15:0];
              next_s.data[{idx, 1'b1}] = mem_rdata[31:16];
              next_s.tag[idx] = s.cur.addr[ADDR_W-1:TAG_LO];
              next_s.valid[idx] = 1'b1;
              next_s.rdata = s.cur.addr[1] ? mem_rdata[31:16] : mem_rdata[15:0];
              next_s.perr = par4(mem_rdata[31:0]) != mem_rdata[35:32];
            end
          end
        end
      end
      default: begin
        next_s.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign periph_ack = s.ack[WHO_MAP];
  assign cpu_ack = s.ack[WHO_CPU];
  assign ctl_ack = s.ack[NUM_CTL:1];
  assign periph_done = s.state == ST_DONE && s.who == WHO_MAP;
  assign cpu_done = s.state == ST_DONE && s.who == WHO_CPU;
  assign periph_parity_err = s.perr && s.who == WHO_MAP;
  assign cpu_parity_abort = s.perr && s.who == WHO_CPU;
  assign periph_rdata = s.rdata;
  assign cpu_rdata = s.rdata;
  assign map_reg_rdata = s.map_rdata;
  assign mem_cmd = s.mem;
  assign ctl_data_out = s.ctl_data;
  assign ctl_data_oe = |ctl_take_data;

  genvar g;
  generate
    for (g = 0; g < NUM_CTL; g++) begin : g_ctl
      assign ctl_gate_addr[g] = s.state == ST_GATE && s.who == who_e'(g + 1);
      assign ctl_drive_data[g] = ctl_gate_addr[g] & ctl_bus_in.transfer_direction;
      assign ctl_take_data[g] = s.state == ST_DONE && s.who == who_e'(g + 1) && !s.cur.write;
    end
  endgenerate

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence seq_read_look;
    s.state == ST_LOOK && !s.cur.write;
  endsequence
  sequence seq_grant;
    s.state == ST_IDLE && |reqv;
  endsequence
  sequence seq_fill_end;
    s.state == ST_MEM && mem_ack && !s.cur.write;
  endsequence

  AST_ONE_ACK: assert property ($onehot0(s.ack))
    else $error("More than one requester acknowledged.");
  AST_MAP_FIRST: assert property (seq_grant and reqv[0] |=> periph_ack)
    else $error("Map request lost arbitration.");
  AST_CPU_LAST: assert property (seq_grant and reqv[0 +: 5] != '0 |=> !cpu_ack)
    else $error("CPU granted over a higher priority request.");
  AST_CTL_GATE: assert property (|ctl_ack |-> ctl_gate_addr == ctl_ack)
    else $error("Granted controller not gated onto the port.");
  AST_HIT_NO_MEM: assert property (seq_read_look and cur_hit |=> !mem_cmd.req && cpu_done | periph_done)
    else $error("Read hit started a memory cycle.");
  AST_MISS_FILL: assert property (seq_read_look and !cur_hit |=> mem_cmd.req && !mem_cmd.write ##0 mem_cmd.byte_mask == MASK_ALL)
    else $error("Read miss did not fetch the whole block.");
  AST_WRITE_THRU: assert property (s.state == ST_LOOK && s.cur.write |=> mem_cmd.req && mem_cmd.write)
    else $error("Write did not reach main memory.");
  AST_CTL_INVAL: assert property (s.state == ST_GATE && ctl_bus_in.transfer_direction && bus_hit |=> !is_hit(s.cur.addr))
    else $error("Controller write left a stale cache entry.");
  AST_IO_SPACE: assert property (periph_in.req && periph_io_space && s.state == ST_IDLE |=> !periph_ack)
    else $error("I/O space address granted a memory cycle.");
  AST_IDENTITY: assert property (!s.reloc |-> phys == {4'h0, periph_in.addr[PADDR_W-1:0]})
    else $error("Map relocated while relocation disabled.");
  AST_REARB: assert property (s.state == ST_DONE |=> s.state == ST_IDLE ##1 s.ack == '0 || s.state != ST_IDLE)
    else $error("Grant held past one memory cycle.");

  // Arbitration and grant timing.
  AST_ACK_AFTER_REQ: assert property (seq_grant |=> $onehot(s.ack))
    else $error("Pending request was not granted.");

  AST_ACK_IN_CYCLE: assert property (|s.ack |-> s.state == ST_LOOK || s.state == ST_GATE)
    else $error("Acknowledge outside the start of a cycle.");

  AST_CTL_ORDER: assert property (seq_grant and !reqv[0] and reqv[1] |=> ctl_ack[0])
    else $error("Controller A lost to a lower priority request.");

  AST_DONE_ONE: assert property (cpu_done || periph_done |=> !cpu_done && !periph_done)
    else $error("Completion held longer than one cycle.");

  // Cache contents: fills, write-through and controller bypass.
  AST_FILL_VALID: assert property (seq_fill_end and (s.who == WHO_MAP || s.who == WHO_CPU) |=> cur_hit)
    else $error("Read miss fill left the block invalid.");

  AST_CTL_NO_FILL: assert property (s.state == ST_MEM && mem_ack && s.who != WHO_MAP && s.who != WHO_CPU |=> $stable(s.valid))
    else $error("Controller transfer changed the cache.");

  AST_HIT_DATA: assert property (seq_read_look and cur_hit |=> s.rdata == s.data[s.cur.addr[TAG_LO-1:1]])
    else $error("Read hit returned a word other than the cached one.");

  AST_WRITE_HIT_UPDATE: assert property (s.state == ST_LOOK && s.cur.write && cur_hit && !s.cur.bytew |=> s.data[s.cur.addr[TAG_LO-1:1]] == s.cur.wdata[WORD_W-1:0])
    else $error("Write hit did not update the cached word.");

  AST_WRITE_NO_ALLOC: assert property (s.state == ST_LOOK && s.cur.write && !cur_hit |=> !cur_hit)
    else $error("Write miss allocated a block.");

  // Memory bus: the request stands until answered, so the address must not move.
  AST_MEM_HOLD: assert property (mem_cmd.req && !mem_ack |=> mem_cmd.req && $stable(mem_cmd.addr))
    else $error("Memory request changed before its answer.");

  AST_ADDR_PARITY: assert property (mem_cmd.req |-> ^{mem_cmd.addr, mem_cmd.write, mem_cmd.byte_mask, mem_cmd.addr_parity})
    else $error("Address and control parity is not odd.");

  // Controller port and map.
  AST_CTL_TAKE: assert property (ctl_data_oe |-> s.state == ST_DONE && !s.cur.write)
    else $error("Controller read data driven outside a read completion.");

  AST_CTL_READ_DWORD: assert property (s.state == ST_GATE && !ctl_bus_in.transfer_direction |=> mem_cmd.byte_mask == MASK_ALL)
    else $error("Controller read not fetched as a double word.");

  AST_CTL_SINGLE_MASK: assert property (s.state == ST_GATE && ctl_bus_in.transfer_direction && !ctl_bus_in.double_word_select |=> mem_cmd.byte_mask != MASK_ALL)
    else $error("Single-word controller write stored both words.");

  AST_MAP_WRITE: assert property (map_reg_we && map_reg_sel != MAP_IO_SEL && !map_reg_hi |=> s.map[$past(map_reg_sel)][WORD_W-1:0] == $past(map_reg_wdata))
    else $error("Map register low half not written.");

  AST_INIT_IDENTITY: assert property (init |=> !s.reloc)
    else $error("Relocation left on during initialize.");
endmodule
`default_nettype wire

// *** logic/cache_pkg.sv ***
/*
  Shared constants, types and carriers of the cache memory port arbiter.
  Assumes one clock domain and word-aligned 22-bit physical byte addresses.
*/
`default_nettype none
package cache_pkg;
  localparam int ADDR_W = 22;
  localparam int MEM_DATA_W = 36;
  localparam int WORD_W = 16;
  localparam int PADDR_W = 18;
  localparam int NUM_CTL = 4;
  localparam int NUM_REQ = 6;
  localparam int CACHE_WORDS = 1024;
  localparam int BLOCKS = 512;
  localparam int IDX_W = 9;
  localparam int TAG_W = 11;
  localparam int IDX_LO = 2;
  localparam int TAG_LO = 11;
  localparam int MAP_REGS = 31;
  localparam int MAP_REG_W = 22;
  localparam int MAP_SEL_LO = 13;
  localparam int MAP_SEL_W = 5;
  localparam int MAP_OFS_W = 13;
  localparam logic [MAP_SEL_W-1:0] MAP_IO_SEL = 5'h1F;
  localparam logic [3:0] MASK_ALL = 4'hF;
  localparam logic [3:0] MASK_LO = 4'h3;
  localparam logic [3:0] MASK_HI = 4'hC;

  typedef enum logic [2:0] {WHO_MAP, WHO_CTL_A, WHO_CTL_B, WHO_CTL_C, WHO_CTL_D, WHO_CPU} who_e;
  typedef enum logic [2:0] {ST_IDLE, ST_GATE, ST_LOOK, ST_MEM, ST_DONE} state_e;

  typedef struct packed {
    logic req;
    logic [ADDR_W-1:0] addr;
    logic transfer_direction;
    logic cycle_modifier;
    logic [WORD_W-1:0] wdata;
  } word_req_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic transfer_direction;
    logic cycle_modifier;
    logic double_word_select;
    logic [MEM_DATA_W-1:0] data;
  } ctl_bus_s;

  typedef struct packed {
    logic req;
    logic [ADDR_W-1:0] addr;
    logic addr_parity;
    logic write;
    logic [3:0] byte_mask;
    logic [MEM_DATA_W-1:0] wdata;
  } mem_cmd_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic dword;
    logic bytew;
    logic [MEM_DATA_W-1:0] wdata;
  } cur_s;

  typedef struct packed {
    state_e state;
    who_e who;
    logic [NUM_REQ-1:0] ack;
    logic perr;
    logic reloc;
    cur_s cur;
    mem_cmd_s mem;
    logic [WORD_W-1:0] rdata;
    logic [MEM_DATA_W-1:0] ctl_data;
    logic [WORD_W-1:0] map_rdata;
    logic [BLOCKS-1:0] valid;
    logic [BLOCKS-1:0][TAG_W-1:0] tag;
    logic [CACHE_WORDS-1:0][WORD_W-1:0] data;
    logic [MAP_REGS-1:0][MAP_REG_W-1:0] map;
  } state_s;
endpackage
`default_nettype wire

// *** verification/main_memory_model.sv ***
/*
  Main memory on the far side of the memory bus, answering lat+1 cycles after a request.
  Assumes one clock and the design's registered request held until the answer.
*/
`timescale 1ns/1ps
`default_nettype none
module main_memory_model (
  input wire logic clk,
  input wire logic nrst,
  input wire cache_pkg::mem_cmd_s mem_cmd,
  input wire logic [3:0] lat,
  output logic mem_ack,
  output logic [cache_pkg::MEM_DATA_W-1:0] mem_rdata,
  output logic [15:0] cycles
);
  import cache_pkg::*;
  logic [31:0] store [logic [19:0]];
  logic [35:0] last;
  logic [3:0] cnt;
  logic [31:0] w;
  // Outside an answer the lines show the inverse, so a stale word is never taken.
  assign mem_rdata = mem_ack ? last : ~last;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      cycles <= 16'h0000;
      last <= 36'h0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
    end else if (mem_cmd.req && cnt < lat) begin
      cnt <= cnt + 4'h1;
    end else if (mem_cmd.req) begin
      w = {mem_cmd.addr[17:2], 1'b1, 15'h0} ^ {mem_cmd.addr[17:2], 1'b0, 15'h0};
      w = {mem_cmd.addr[17:2], 1'b1} ^ 16'h5A3C;
      w = {w[15:0], 16'({mem_cmd.addr[17:2], 1'b0}) ^ 16'h5A3C};
      if (store.exists(mem_cmd.addr[21:2])) w = store[mem_cmd.addr[21:2]];
      for (int i = 0; i < 4; i++) begin
        if (mem_cmd.write && mem_cmd.byte_mask[i]) w[8*i+:8] = mem_cmd.wdata[8*i+:8];
      end
      if (mem_cmd.write) store[mem_cmd.addr[21:2]] = w;
      last <= {~^w[31:24], ~^w[23:16], ~^w[15:8], ~^w[7:0], w};
      mem_ack <= 1'b1;
      cycles <= cycles + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// *** verification/test_cache_memory_port_arbiter.sv ***
/*
  Self-checking bench of the memory port arbiter with a main memory model.
  Assumes controllers drive the shared bus only while gated.
*/
`timescale 1ns/1ps
`default_nettype none
module test_cache_memory_port_arbiter;
  import cache_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic init = 1'b1;
  logic relocation_enable = 1'b0;
  word_req_s periph_in = '0;
  word_req_s cpu_in = '0;
  logic map_reg_we = 1'b0;
  logic [4:0] map_reg_sel = 5'h05;
  logic map_reg_hi = 1'b0;
  logic [15:0] map_reg_wdata = 16'h0000;
  logic [3:0] ctl_req = 4'h0;
  logic [3:0] lat = 4'h1;
  ctl_bus_s ctl_bus_in;
  ctl_bus_s bus_last = '0;
  ctl_bus_s ctl_val [4];
  logic periph_ack, periph_done, periph_parity_err, periph_io_space, cpu_ack, cpu_done;
  logic cpu_parity_abort, ctl_data_oe, mem_ack;
  logic [15:0] periph_rdata, map_reg_rdata, cpu_rdata, cycles, base_cycles;
  logic [3:0] ctl_ack, ctl_gate_addr, ctl_drive_data, ctl_take_data;
  logic [35:0] ctl_data_out, mem_rdata;
  mem_cmd_s mem_cmd;
  logic [2:0] got;
  logic [21:0] a, pa;
  int fails = 0;
  int checks = 0;
  integer seed = 95;
  logic [2:0] who_q[$];
  logic [36:0] dat_q[$];
  logic [15:0] shadow [logic [20:0]];
  cache_memory_port_arbiter dut (.clk, .nrst, .init, .relocation_enable, .periph_in, .periph_ack,
    .periph_done, .periph_parity_err, .periph_io_space, .periph_rdata, .map_reg_we, .map_reg_sel,
    .map_reg_hi, .map_reg_wdata, .map_reg_rdata, .cpu_in, .cpu_ack, .cpu_done, .cpu_parity_abort,
    .cpu_rdata, .ctl_req, .ctl_ack, .ctl_gate_addr, .ctl_drive_data, .ctl_take_data, .ctl_bus_in,
    .ctl_data_out, .ctl_data_oe, .mem_cmd, .mem_ack, .mem_rdata);
  main_memory_model mem (.clk, .nrst, .mem_cmd, .lat, .mem_ack, .mem_rdata, .cycles);
  always #12.5 clk = ~clk;
  // A released shared bus shows the inverse of its last value.
  always_comb begin
    ctl_bus_in = ~bus_last;
    for (int i = 0; i < 4; i++) if (ctl_gate_addr[i]) ctl_bus_in = ctl_val[i];
  end
  always @(posedge clk) if (|ctl_gate_addr) bus_last <= ctl_bus_in;
  task automatic cmp(input logic [35:0] g, input logic [35:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_who(input logic [2:0] g, input logic [2:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t grant %0d expected %0d", $time, g, e);
    end
  endtask
  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  function automatic logic [15:0] expw(input logic [21:0] x);
    return shadow.exists(x[21:1]) ? shadow[x[21:1]] : x[16:1] ^ 16'h5A3C;
  endfunction
  task automatic word_op(input logic m, input logic wr, input logic [21:0] ra,
      input logic [21:0] ph, input logic [15:0] d, input logic note);
    int n;
    word_req_s r;
    r = '{req: 1'b1, addr: ra, transfer_direction: wr, cycle_modifier: 1'b0, wdata: d};
    if (note) who_q.push_back(m ? 3'h0 : 3'h5);
    if (note) dat_q.push_back({~wr, 20'h0, expw(ph)});
    if (wr) shadow[ph[21:1]] = d;
    if (m) periph_in = r;
    else cpu_in = r;
    for (n = 0; n < 300 && !(m ? periph_done : cpu_done); n++) tick();
    if (n == 300) begin
      fails++;
      close_out();
    end
    tick();
    r.req = 1'b0;
    if (m) periph_in = r;
    else cpu_in = r;
  endtask
  task automatic ctl_op(input int i, input logic wr, input logic [21:0] ca, input logic [31:0] d,
      input logic dw, input logic note);
    int n;
    logic [31:0] w;
    ctl_val[i] = '{addr: ca, transfer_direction: wr, cycle_modifier: 1'b0, double_word_select: dw,
      data: {4'h0, d}};
    w = {expw({ca[21:2], 2'h2}), expw({ca[21:2], 2'h0})};
    if (note) who_q.push_back(3'(i + 1));
    if (!wr) dat_q.push_back({1'b1, ~^w[31:24], ~^w[23:16], ~^w[15:8], ~^w[7:0], w});
    if (wr && dw) shadow[{ca[21:2], 1'b0}] = d[15:0];
    if (wr && dw) shadow[{ca[21:2], 1'b1}] = d[31:16];
    if (wr && !dw) shadow[ca[21:1]] = d[15:0];
    ctl_req[i] = 1'b1;
    for (n = 0; n < 300 && !ctl_ack[i]; n++) tick();
    tick();
    ctl_req[i] = 1'b0;
    for (; n < 300 && !wr && !ctl_take_data[i]; n++) tick();
    if (n == 300) begin
      fails++;
      close_out();
    end
  endtask
  // Results are noted by the drivers and matched here in order of appearance.
  always @(posedge clk) begin
    #2;
    if (nrst && (periph_ack | cpu_ack | (|ctl_ack))) begin
      got = periph_ack ? 3'h0 : cpu_ack ? 3'h5 : ctl_ack[0] ? 3'h1 : ctl_ack[1] ? 3'h2 : ctl_ack[2] ? 3'h3 : 3'h4;
      cmp_who(got, who_q.size() ? who_q.pop_front() : 3'h7);
    end
    if (nrst && (periph_done | cpu_done | (|ctl_take_data))) begin
      if (dat_q.size() == 0) cmp(36'h1, 36'h0);
      else if (dat_q[0][36]) cmp(periph_done ? {20'h0, periph_rdata} : cpu_done ? {20'h0, cpu_rdata} : ctl_data_out, dat_q[0][35:0]);
      if (dat_q.size()) void'(dat_q.pop_front());
      cmp({35'h0, cpu_parity_abort | periph_parity_err}, 36'h0);
    end
  end
  initial begin
    for (int i = 0; i < 4; i++) ctl_val[i] = '0;
    repeat (16) @(posedge clk);
    #1;
    nrst = 1'b1;
    init = 1'b0;
    word_op(1'b1, 1'b0, 22'h00A46, 22'h00A46, 16'h0000, 1'b1);
    who_q = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
    dat_q = '{37'h0, 37'h0};
    fork
      word_op(1'b1, 1'b1, 22'h00100, 22'h00100, 16'($random(seed)), 1'b0);
      ctl_op(0, 1'b1, 22'h01000, $random(seed), 1'b1, 1'b0);
      ctl_op(1, 1'b1, 22'h01008, $random(seed), 1'b1, 1'b0);
      ctl_op(2, 1'b1, 22'h01010, $random(seed), 1'b1, 1'b0);
      ctl_op(3, 1'b1, 22'h01018, $random(seed), 1'b1, 1'b0);
      word_op(1'b0, 1'b1, 22'h200, 22'h200, 16'($random(seed)), 1'b0);
    join
    a = 22'h312344;
    lat = 4'($unsigned($random(seed)) % 6);
    base_cycles = cycles;
    word_op(1'b0, 1'b0, a, a, 16'h0000, 1'b1);
    word_op(1'b0, 1'b0, a ^ 22'h2, a ^ 22'h2, 16'h0000, 1'b1);
    cmp({20'h0, cycles - base_cycles}, 36'h1);
    word_op(1'b0, 1'b1, a, a, 16'($random(seed)), 1'b1);
    word_op(1'b0, 1'b0, a, a, 16'h0000, 1'b1);
    cmp({20'h0, cycles - base_cycles}, 36'h2);
    ctl_op(1, 1'b0, a, 32'h0, 1'b1, 1'b1);
    ctl_op(2, 1'b1, a, $random(seed), 1'b1, 1'b1);
    word_op(1'b0, 1'b0, a, a, 16'h0000, 1'b1);
    cmp({20'h0, cycles - base_cycles}, 36'h5);
    a = 22'h02A3C0;
    word_op(1'b0, 1'b1, a, a, 16'($random(seed)), 1'b1);
    word_op(1'b0, 1'b0, a, a, 16'h0000, 1'b1);
    cmp({20'h0, cycles - base_cycles}, 36'h7);
    ctl_op(3, 1'b1, a | 22'h2, {2{16'hC3A5}}, 1'b0, 1'b1);
    word_op(1'b0, 1'b0, a | 22'h2, a | 22'h2, 16'h0000, 1'b1);
    cmp({20'h0, cycles - base_cycles}, 36'h9);
    map_reg_we = 1'b1;
    map_reg_wdata = 16'hBCDE;
    tick();
    map_reg_hi = 1'b1;
    map_reg_wdata = 16'h000A;
    tick();
    map_reg_we = 1'b0;
    tick();
    cmp({20'h0, map_reg_rdata}, 36'h0000A);
    relocation_enable = 1'b1;
    tick();
    tick();
    pa = 22'h00A124;
    word_op(1'b1, 1'b0, pa, {22'h0ABCDE & 22'h3FFFFE} + 22'(pa[12:0]), 16'h0000, 1'b1);
    periph_in = '{req: 1'b1, addr: 22'h03E010, transfer_direction: 1'b0, cycle_modifier: 1'b0, wdata: 16'h0};
    repeat (20) tick();
    cmp({35'h0, periph_io_space}, 36'h1);
    periph_in.req = 1'b0;
    relocation_enable = 1'b0;
    init = 1'b1;
    tick();
    init = 1'b0;
    tick();
    word_op(1'b1, 1'b0, pa, pa, 16'h0000, 1'b1);
    close_out();
  end
endmodule
`default_nettype wire
